// File: src/sphp_pkg.sv
package sphp_pkg;

  // Clocking
  localparam int CLK_PERIOD_NS = 8;

  // Port map on the link, selected by the port line
  localparam logic PORT_DATA = 1'b0;
  localparam logic PORT_CTRL = 1'b1;

  // Control/status port layout
  localparam int CTL_INT_EN_BIT  = 7;
  localparam int CTL_INT_CLR_BIT = 6;
  localparam int STS_TYPE_LSB    = 1;
  localparam int STS_HS_BIT      = 0;

  // Reset values of the two ports
  localparam logic [7:0] DATA_PORT_RST = 8'hDF;
  localparam logic [7:0] CTRL_PORT_RST = 8'h00;

  // Interface select code that picks the parallel port
  localparam logic [1:0] IO_SEL_PARALLEL = 2'h2;

  // Pending message types
  typedef enum logic [2:0] {
    MSG_NONE   = 3'h0,
    MSG_ROW    = 3'h1,
    MSG_PIXEL  = 3'h2,
    MSG_HIST   = 3'h3,
    MSG_AUTH   = 3'h4,
    MSG_REGS   = 3'h5,
    MSG_SINGLE = 3'h6
  } sphp_msg_e;

  localparam int LEN_W = 7;

  // Byte count of each message type
  function automatic logic [LEN_W-1:0] sphp_msg_len(input logic [2:0] t);
    case (t)
      MSG_ROW:    sphp_msg_len = 7'h01;
      MSG_PIXEL:  sphp_msg_len = 7'h08;
      MSG_HIST:   sphp_msg_len = 7'h21;
      MSG_AUTH:   sphp_msg_len = 7'h09;
      MSG_REGS:   sphp_msg_len = 7'h72;
      MSG_SINGLE: sphp_msg_len = 7'h02;
      default:    sphp_msg_len = 7'h00;
    endcase
  endfunction

  // Device port state machine
  typedef enum logic {
    DEV_IDLE = 1'b0,
    DEV_HOLD = 1'b1
  } sphp_dev_e;

  // Host cycle state machine, gray coded along the cycle
  typedef enum logic [1:0] {
    HST_IDLE   = 2'h0,
    HST_SETUP  = 2'h1,
    HST_STROBE = 2'h3,
    HST_RECOV  = 2'h2
  } sphp_hst_e;

  // Host address/data setup before the strobe falls
  localparam int SETUP_NS  = 16;
  localparam int SETUP_CYC = ((SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) < 1 ? 1 :
                             ((SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int SETUP_W   = 4;

  // Host controller APB map
  localparam int         APB_AW        = 12;
  localparam logic [11:0] HREG_CMD     = 12'h000;
  localparam logic [11:0] HREG_STATUS  = 12'h004;
  localparam logic [11:0] HREG_INT_STS = 12'h008;
  localparam logic [11:0] HREG_INT_MSK = 12'h00C;

  // Command register fields
  localparam int CMD_START_BIT = 0;
  localparam int CMD_READ_BIT  = 1;
  localparam int CMD_PORT_BIT  = 2;
  localparam int CMD_DATA_LSB  = 8;

  // Status register fields
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DATA_LSB = 8;

  // Interrupt status bits
  localparam int INT_DONE_BIT = 0;
  localparam int INT_DEV_BIT  = 1;
  localparam int INT_W        = 2;

endpackage

// File: src/sphp_if.sv
`timescale 1ns/1ps
`default_nettype none
interface sphp_if;
  logic       cs_n;
  logic       io_read_strobe_n;
  logic       io_write_strobe_n;
  logic       port_select_line;
  logic [7:0] host_data;
  logic       host_data_oe_n;
  logic [7:0] dev_data;
  logic       dev_data_oe_n;
  logic       ready;
  logic       ready_oe_n;
  logic       irq;
  logic       irq_oe_n;

  // Resolved wire levels; undriven ready and irq are pulled low
  wire  [7:0] data_bus  = !host_data_oe_n ? host_data : (!dev_data_oe_n ? dev_data : 8'hFF);
  wire        ready_pin = !ready_oe_n & ready;
  wire        irq_pin   = !irq_oe_n & irq;

  modport dev (
    input  cs_n, io_read_strobe_n, io_write_strobe_n, port_select_line, data_bus,
    output dev_data, dev_data_oe_n, ready, ready_oe_n, irq, irq_oe_n
  );

  modport host (
    output cs_n, io_read_strobe_n, io_write_strobe_n, port_select_line,
    output host_data, host_data_oe_n,
    input  data_bus, ready_pin, irq_pin
  );
endinterface
`default_nettype wire

// File: src/sphp_dev.sv
// Overview of operation
// - Host decodes upper address, drives chip select
// - Port works only when select pins choose it
// - Port 0: address then value; reads stream data
// - Port 1 reads status, chosen by port line
// - Interrupt when any message becomes ready
// - Strobes synchronised; act on their edges
// - Power-up in polled mode, enable bit zero
// - Master reset keeps interrupt mode setting
// - Interrupt held until a port 1 write sets bit 6 or clears bit 7
// - Early clear not reasserted for same message
// - Queued message may reassert after last byte
// - Ready low idle, high to let cycle finish
// - Control bit 7 selects interrupt mode
// - Status bits 3:1 give pending message type
// - Status bit 0 active-low data available
`timescale 1ns/1ps
`default_nettype none
module sphp_dev
  import sphp_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // Link to the host
  sphp_if.dev             link,
  // Chip configuration
  input  wire logic [1:0] io_sel,
  input  wire logic       master_reset,
  // Message bytes from the sensor core
  input  wire logic       src_valid,
  input  wire logic [2:0] src_type,
  input  wire logic [7:0] src_data,
  output logic            src_ready,
  // Register writes towards the sensor core
  output logic            cmd_valid,
  output logic [7:0]      cmd_addr,
  output logic [7:0]      cmd_data,
  // Mode seen by the core
  output logic            int_mode
);

  ////////////////////////////////////////////////////////////////////////////////
  // Synchronisers: first stage feeds only the second

  logic [11:0] sync1_r;
  logic [11:0] sync2_r;
  logic        rd_q_r;
  logic        wr_q_r;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sync1_r <= 12'hFFF;
      sync2_r <= 12'hFFF;
      rd_q_r  <= 1'b1;
      wr_q_r  <= 1'b1;
    end else begin
      sync1_r <= {link.cs_n, link.io_read_strobe_n, link.io_write_strobe_n,
                  link.port_select_line, link.data_bus};
      sync2_r <= sync1_r;
      rd_q_r  <= sync2_r[10];
      wr_q_r  <= sync2_r[9];
    end
  end

  wire       cs_s     = ~sync2_r[11];
  wire       rd_s     = ~sync2_r[10];
  wire       wr_s     = ~sync2_r[9];
  wire       port_s   = sync2_r[8];
  wire [7:0] bus_s    = sync2_r[7:0];
  wire       selected = (io_sel == IO_SEL_PARALLEL);
  wire       rd_fall  = rd_q_r & rd_s;
  wire       wr_fall  = wr_q_r & wr_s;

  ////////////////////////////////////////////////////////////////////////////////
  // Access decode

  sphp_dev_e state_r;
  sphp_dev_e state_nxt;

  wire start     = selected && cs_s && (state_r == DEV_IDLE) && (rd_fall || wr_fall);
  wire is_read   = start && rd_s;
  wire is_write  = start && !rd_s;
  wire rd_data   = is_read && (port_s == PORT_DATA);
  wire rd_ctrl   = is_read && (port_s == PORT_CTRL);
  wire wr_data   = is_write && (port_s == PORT_DATA);
  wire wr_ctrl   = is_write && (port_s == PORT_CTRL);
  wire released  = !rd_s && !wr_s;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      DEV_IDLE: begin
        if (start) state_nxt = DEV_HOLD;
      end
      DEV_HOLD: begin
        if (released || !selected) state_nxt = DEV_IDLE;
      end
      default: state_nxt = DEV_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Message buffer

  logic [7:0]       cur_byte_r;
  logic             cur_valid_r;
  logic [2:0]       msg_type_r;
  logic [LEN_W-1:0] remain_r;

  wire msg_first  = (remain_r == '0);
  wire load       = src_valid && !cur_valid_r;
  wire pop        = rd_data && cur_valid_r;
  wire msg_active = cur_valid_r || !msg_first;
  wire [2:0] type_shown = msg_active ? msg_type_r : MSG_NONE;

  assign src_ready = !cur_valid_r;

  always_ff @(posedge clk) begin
    if (sys_rst || master_reset) begin
      cur_valid_r <= 1'b0;
      msg_type_r  <= MSG_NONE;
      remain_r    <= '0;
    end else begin
      if (load) begin
        cur_valid_r <= 1'b1;
        if (msg_first) begin
          msg_type_r <= src_type;
          remain_r   <= sphp_msg_len(src_type) - 7'h01;
        end else begin
          remain_r   <= remain_r - 7'h01;
        end
      end else if (pop) begin
        cur_valid_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cur_byte_r <= DATA_PORT_RST;
    end else if (load) begin
      cur_byte_r <= src_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Control, interrupt and write pairing

  logic       int_en_r;
  logic       irq_pend_r;
  logic       hs_n_r;
  logic       addr_phase_r;
  logic [7:0] out_r;
  logic       ready_r;

  // Only the first byte of a message raises the request, so an early clear
  // leaves the rest of that message silent
  wire irq_set = load && msg_first && int_en_r;
  wire irq_clr = wr_ctrl && bus_s[CTL_INT_CLR_BIT];
  wire [7:0] status = {int_en_r, 1'b0, 2'b00, type_shown, hs_n_r};

  // Mode bit ignores the core's master reset
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      int_en_r <= CTRL_PORT_RST[CTL_INT_EN_BIT];
    end else if (wr_ctrl) begin
      int_en_r <= bus_s[CTL_INT_EN_BIT];
    end
  end

  // Set wins over a clear in the same cycle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_pend_r <= 1'b0;
    end else if (irq_set) begin
      irq_pend_r <= 1'b1;
    end else if (irq_clr || !int_en_r) begin
      irq_pend_r <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      hs_n_r <= CTRL_PORT_RST[STS_HS_BIT];
    end else begin
      hs_n_r <= !cur_valid_r;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst || master_reset) begin
      addr_phase_r <= 1'b1;
    end else if (wr_data) begin
      addr_phase_r <= !addr_phase_r;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cmd_valid <= 1'b0;
      cmd_addr  <= 8'h00;
      cmd_data  <= 8'h00;
    end else begin
      cmd_valid <= wr_data && !addr_phase_r;
      if (wr_data && addr_phase_r) cmd_addr <= bus_s;
      if (wr_data && !addr_phase_r) cmd_data <= bus_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Link outputs

  // Without a byte ready, a data read returns the idle pattern
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      out_r   <= DATA_PORT_RST;
      ready_r <= 1'b0;
      state_r <= DEV_IDLE;
    end else begin
      if (rd_data) out_r <= cur_valid_r ? cur_byte_r : DATA_PORT_RST;
      if (rd_ctrl) out_r <= status;
      ready_r <= (state_nxt == DEV_HOLD);
      state_r <= state_nxt;
    end
  end

  assign link.dev_data      = out_r;
  assign link.dev_data_oe_n = !(selected && cs_s && rd_s && state_r == DEV_HOLD);
  assign link.ready         = ready_r;
  assign link.ready_oe_n    = !selected;
  assign link.irq           = irq_pend_r;
  assign link.irq_oe_n      = !selected;
  assign int_mode           = int_en_r;

endmodule
`default_nettype wire

// File: src/sphp_host.sv
`timescale 1ns/1ps
`default_nettype none
module sphp_host
  import sphp_pkg::*;
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              sys_rst,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [APB_AW-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Interrupt
  output logic                   irq_out,
  // Link to the sensor
  sphp_if.host                   link
);

  ////////////////////////////////////////////////////////////////////////////////
  // APB decode

  wire acc      = psel && penable;
  wire wr       = acc && pwrite;
  wire sel_cmd  = (paddr == HREG_CMD);
  wire sel_stat = (paddr == HREG_STATUS);
  wire sel_ists = (paddr == HREG_INT_STS);
  wire sel_imsk = (paddr == HREG_INT_MSK);

  sphp_hst_e        state_r;
  logic [7:0]       wdata_r;
  logic [7:0]       rdata_r;
  logic             read_r;
  logic             port_r;
  logic [SETUP_W-1:0] cnt_r;
  logic [INT_W-1:0] ists_r;
  logic [INT_W-1:0] imsk_r;
  logic [1:0]       rdy_sync_r;
  logic [2:0]       irq_sync_r;

  wire busy   = (state_r != HST_IDLE);
  wire launch = wr && sel_cmd && pwdata[CMD_START_BIT] && !busy;
  wire rdy_s  = rdy_sync_r[1];
  wire done   = (state_r == HST_RECOV) && !rdy_s;
  wire dev_ev = irq_sync_r[1] && !irq_sync_r[2];

  ////////////////////////////////////////////////////////////////////////////////
  // Link cycle

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdy_sync_r <= 2'b00;
      irq_sync_r <= 3'b000;
    end else begin
      rdy_sync_r <= {rdy_sync_r[0], link.ready_pin};
      irq_sync_r <= {irq_sync_r[1:0], link.irq_pin};
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_r <= HST_IDLE;
      cnt_r   <= '0;
      wdata_r <= 8'h00;
      read_r  <= 1'b0;
      port_r  <= PORT_DATA;
      rdata_r <= 8'h00;
    end else begin
      case (state_r)
        HST_IDLE: begin
          if (launch) begin
            state_r <= HST_SETUP;
            cnt_r   <= SETUP_W'(SETUP_CYC);
            wdata_r <= pwdata[CMD_DATA_LSB +: 8];
            read_r  <= pwdata[CMD_READ_BIT];
            port_r  <= pwdata[CMD_PORT_BIT];
          end
        end
        HST_SETUP: begin
          cnt_r <= cnt_r - 1'b1;
          if (cnt_r == SETUP_W'(1) && !rdy_s) state_r <= HST_STROBE;
        end
        HST_STROBE: begin
          if (rdy_s) begin
            state_r <= HST_RECOV;
            if (read_r) rdata_r <= link.data_bus;
          end
        end
        HST_RECOV: begin
          if (!rdy_s) state_r <= HST_IDLE;
        end
        default: state_r <= HST_IDLE;
      endcase
    end
  end

  assign link.cs_n              = !busy;
  assign link.port_select_line  = port_r;
  assign link.io_read_strobe_n  = !(state_r == HST_STROBE && read_r);
  assign link.io_write_strobe_n = !(state_r == HST_STROBE && !read_r);
  assign link.host_data         = wdata_r;
  assign link.host_data_oe_n    = !((state_r == HST_SETUP || state_r == HST_STROBE) && !read_r);

  ////////////////////////////////////////////////////////////////////////////////
  // Interrupt status, write one to clear; a new event beats the clear

  wire [INT_W-1:0] ev = {dev_ev, done};
  wire [INT_W-1:0] w1c = (wr && sel_ists) ? pwdata[INT_W-1:0] : '0;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ists_r <= '0;
      imsk_r <= '0;
    end else begin
      ists_r <= (ists_r & ~w1c) | ev;
      if (wr && sel_imsk) imsk_r <= pwdata[INT_W-1:0];
    end
  end

  assign irq_out = |(ists_r & imsk_r);
  assign pready  = 1'b1;
  assign pslverr = 1'b0;

  always_comb begin
    prdata = 32'h0000_0000;
    if (sel_cmd) begin
      prdata[CMD_READ_BIT]          = read_r;
      prdata[CMD_PORT_BIT]          = port_r;
      prdata[CMD_DATA_LSB +: 8]     = wdata_r;
    end else if (sel_stat) begin
      prdata[STAT_BUSY_BIT]         = busy;
      prdata[STAT_DATA_LSB +: 8]    = rdata_r;
    end else if (sel_ists) begin
      prdata[INT_W-1:0]             = ists_r;
    end else if (sel_imsk) begin
      prdata[INT_W-1:0]             = imsk_r;
    end
  end

endmodule
`default_nettype wire

// File: test/sphp_link_props.sv
`timescale 1ns/1ps
`default_nettype none
module sphp_link_props (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Link signals
  input wire logic cs_n,
  input wire logic io_read_strobe_n,
  input wire logic io_write_strobe_n,
  input wire logic port_select_line,
  input wire logic host_data_oe_n,
  input wire logic dev_data_oe_n,
  input wire logic ready,
  input wire logic ready_oe_n,
  input wire logic irq,
  input wire logic irq_oe_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  ////////////////////////////////////////
  // Cycles since the last write to the control port
  logic [4:0] since_clr_r;
  wire        clr_wr = !cs_n && !io_write_strobe_n && port_select_line;
  always_ff @(posedge clk) begin
    if (sys_rst || clr_wr) since_clr_r <= 5'h00;
    else if (since_clr_r != 5'h1F) since_clr_r <= since_clr_r + 5'h01;
  end

  sequence strobe_fall;
    !cs_n && ($fell(io_read_strobe_n) || $fell(io_write_strobe_n));
  endsequence
  sequence strobe_rise;
    $rose(io_read_strobe_n) || $rose(io_write_strobe_n);
  endsequence

  ////////////////////////////////////////
  chk_ready_idle: assert property (strobe_fall |-> !ready)
    else $error("ready high as a cycle starts");
  chk_sync_gap: assert property (strobe_fall |-> !ready ##1 !ready)
    else $error("ready before strobe synchronised");
  chk_ready_answer: assert property (strobe_fall ##0 !ready_oe_n |-> ##[2:8] ready)
    else $error("ready did not answer the strobe");
  chk_ready_stands: assert property (
    ready && !cs_n && !(io_read_strobe_n && io_write_strobe_n) |=> ready)
    else $error("ready dropped while strobe low");
  chk_ready_release: assert property (strobe_rise ##0 ready |-> ##[1:8] !ready)
    else $error("ready stuck after strobe rose");
  chk_read_drive: assert property (
    $fell(dev_data_oe_n) |-> !cs_n && !io_read_strobe_n)
    else $error("device drove data outside a read");
  chk_no_clash: assert property (!host_data_oe_n |-> dev_data_oe_n)
    else $error("both ends drive the data bus");
  chk_desel_quiet: assert property (ready_oe_n |-> irq_oe_n && dev_data_oe_n)
    else $error("deselected port drives a pin");
  chk_irq_hold: assert property ($fell(irq) |-> since_clr_r < 5'h14)
    else $error("interrupt fell without a clear write");
endmodule
`default_nettype wire

// File: test/test_sensor_parallel_host_port.sv
`timescale 1ns/1ps
`default_nettype none
module test_sensor_parallel_host_port import sphp_pkg::*;;
  logic        clk = 1'b0, sys_rst = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic        pready, pslverr, irq_out, src_ready, cmd_valid, int_mode;
  logic [1:0]  io_sel = IO_SEL_PARALLEL;
  logic        master_reset = 1'b0, src_valid = 1'b0;
  logic [2:0]  src_type = 3'h0;
  logic [7:0]  src_data = 8'h00, cmd_addr, cmd_data;
  logic [31:0] seed = 32'hD695132E;
  logic [7:0]  exp_q[$];
  int          failures = 0, n_checks = 0, cyc = 0, n_cmd = 0;
  int          lens[7] = '{0, 1, 8, 33, 9, 114, 2};

  always #(CLK_PERIOD_NS / 2) clk = ~clk;

  sphp_if u_sphp_if ();
  sphp_dev u_sphp_dev (.clk(clk), .sys_rst(sys_rst), .link(u_sphp_if.dev),
    .io_sel(io_sel), .master_reset(master_reset), .src_valid(src_valid),
    .src_type(src_type), .src_data(src_data), .src_ready(src_ready),
    .cmd_valid(cmd_valid), .cmd_addr(cmd_addr), .cmd_data(cmd_data), .int_mode(int_mode));
  sphp_host u_sphp_host (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq_out(irq_out), .link(u_sphp_if.host));
  sphp_link_props u_sphp_link_props (.clk(clk), .sys_rst(sys_rst), .cs_n(u_sphp_if.cs_n),
    .io_read_strobe_n(u_sphp_if.io_read_strobe_n),
    .io_write_strobe_n(u_sphp_if.io_write_strobe_n),
    .port_select_line(u_sphp_if.port_select_line),
    .host_data_oe_n(u_sphp_if.host_data_oe_n), .dev_data_oe_n(u_sphp_if.dev_data_oe_n),
    .ready(u_sphp_if.ready), .ready_oe_n(u_sphp_if.ready_oe_n), .irq(u_sphp_if.irq),
    .irq_oe_n(u_sphp_if.irq_oe_n));

  ////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Status byte: mode, zeros, type, active-low available
  function automatic logic [7:0] sts(input logic en, input logic [2:0] t);
    return {en, 3'h0, t, t == 3'h0};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic summarize;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // Request stands until pready is seen high at a rising edge; data is taken there
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask

  task automatic link(input logic r, input logic p, input logic [7:0] d,
                      output logic [7:0] q);
    logic [31:0] s;
    wr(HREG_CMD, {16'h0000, d, 5'h00, p, r, 1'b1});
    s = 32'h1;
    while (s[STAT_BUSY_BIT] !== 1'b0) apb(1'b0, HREG_STATUS, 32'h0, s);
    q = s[STAT_DATA_LSB +: 8];
  endtask

  task automatic feed(input logic [2:0] t, input int n);
    for (int i = 0; i < n; i++) begin
      seed = lfsr(seed);
      src_valid <= 1'b1;
      src_type <= t;
      src_data <= seed[7:0];
      exp_q.push_back(seed[7:0]);
      do begin
        @(posedge clk);
      end while (src_ready !== 1'b1);
    end
    src_valid <= 1'b0;
  endtask

  task automatic drain(input int n);
    logic [7:0] q;
    repeat (n) begin
      link(1'b1, PORT_DATA, 8'h00, q);
      chk(q, exp_q.pop_front());
    end
  endtask

  task automatic wait_irq;
    for (int k = 0; k < 64 && u_sphp_if.irq_pin !== 1'b1; k++) @(posedge clk);
  endtask

  always @(negedge clk) if (cmd_valid === 1'b1) n_cmd++;

  // Whole run is a few thousand cycles; the ceiling only cuts a hang
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      failures++;
      summarize();
    end
  end

  ////////////////////////////////////////
  initial begin
    logic [7:0] q, a, v;
    logic [31:0] w;
    int c;
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    link(1'b1, PORT_CTRL, 8'h00, q);
    chk(q, sts(1'b0, 3'h0));
    chk(int_mode, 1'b0);
    link(1'b1, PORT_DATA, 8'h00, q);
    chk(q, DATA_PORT_RST);
    apb(1'b0, 12'h010, 32'h0, w);
    chk(w, 32'h0);
    chk(pslverr, 1'b0);
    $display("done: reset");
    for (int t = 1; t < 7; t++) begin
      fork
        feed(t[2:0], lens[t]);
      join_none
      repeat (4) @(posedge clk);
      link(1'b1, PORT_CTRL, 8'h00, q);
      chk(q, sts(1'b0, t[2:0]));
      drain(lens[t]);
      link(1'b1, PORT_CTRL, 8'h00, q);
      chk(q, sts(1'b0, 3'h0));
    end
    $display("done: messages");
    repeat (4) begin
      c = n_cmd;
      seed = lfsr(seed);
      a = seed[7:0];
      v = seed[15:8];
      link(1'b0, PORT_DATA, a, q);
      link(1'b0, PORT_DATA, v, q);
      chk({cmd_addr, cmd_data}, {a, v});
      chk(32'(n_cmd - c), 32'h1);
    end
    $display("done: writes");
    wr(HREG_INT_MSK, 32'h0);
    wr(HREG_INT_STS, 32'h3);
    link(1'b0, PORT_CTRL, 8'h80, q);
    link(1'b1, PORT_CTRL, 8'h00, q);
    chk(q, sts(1'b1, 3'h0));
    master_reset <= 1'b1;
    @(posedge clk);
    master_reset <= 1'b0;
    @(posedge clk);
    link(1'b1, PORT_CTRL, 8'h00, q);
    chk(q, sts(1'b1, 3'h0));
    fork
      feed(3'h6, 2);
    join_none
    wait_irq();
    chk(u_sphp_if.irq_pin, 1'b1);
    // Host sees the pin only after two flops and its edge detector
    repeat (4) @(posedge clk);
    apb(1'b0, HREG_INT_STS, 32'h0, w);
    chk(w[INT_DEV_BIT], 1'b1);
    chk(irq_out, 1'b0);
    wr(HREG_INT_MSK, 32'h2);
    apb(1'b0, HREG_INT_MSK, 32'h0, w);
    chk(w, 32'h2);
    chk(irq_out, 1'b1);
    wr(HREG_INT_STS, 32'h2);
    chk(irq_out, 1'b0);
    drain(1);
    chk(u_sphp_if.irq_pin, 1'b1);
    link(1'b0, PORT_CTRL, 8'hC0, q);
    repeat (4) @(posedge clk);
    chk(u_sphp_if.irq_pin, 1'b0);
    link(1'b1, PORT_CTRL, 8'h00, q);
    chk(q, sts(1'b1, 3'h6));
    drain(1);
    repeat (8) @(posedge clk);
    chk(u_sphp_if.irq_pin, 1'b0);
    fork
      begin
        feed(3'h1, 1);
        @(posedge clk);
        feed(3'h1, 1);
      end
    join_none
    wait_irq();
    link(1'b0, PORT_CTRL, 8'hC0, q);
    drain(1);
    wait_irq();
    chk(u_sphp_if.irq_pin, 1'b1);
    link(1'b0, PORT_CTRL, 8'hC0, q);
    drain(1);
    link(1'b0, PORT_CTRL, 8'h00, q);
    chk(int_mode, 1'b0);
    $display("done: interrupts");
    io_sel <= 2'h0;
    repeat (6) @(posedge clk);
    chk({u_sphp_if.ready_oe_n, u_sphp_if.irq_oe_n, u_sphp_if.dev_data_oe_n}, 3'h7);
    chk(u_sphp_if.data_bus, 8'hFF);
    io_sel <= IO_SEL_PARALLEL;
    $display("done: deselect");
    summarize();
  end
endmodule
`default_nettype wire
